// [dv/frm_chk.sv]
// Pin-level checker for the two-wire memory slave.
// Assumes it is bound to frm_slave and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module frm_chk (
    // Clock, reset, pins and status.
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic busy,
    input wire logic [10:0] last_addr
);
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // The pin may only ever pull low, and only while a transfer is in progress.
    AST_PULL_LOW: assert property ((sda_out == 1'b0) && (!sda_oe || busy)) else $error("bad data drive");
    AST_DRIVE_ON_LOW: assert property ($rose(sda_oe) |-> !scl_in) else $error("drive with clock high");
    AST_FREE_ON_LOW: assert property ($fell(sda_oe) |-> !scl_in) else $error("release with clock high");
    AST_DRIVE_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("drive too short");
    AST_IDLE_QUIET: assert property (!busy && !$past(busy) |-> !sda_oe) else $error("idle slave drives");
    AST_STOP_IDLE: assert property (scl_in && $rose(sda_in) |-> ##[1:8] !busy) else $error("stop ignored");
    AST_START_BUSY: assert property (scl_in && $fell(sda_in) |-> ##[1:8] busy) else $error("start ignored");
    AST_ADDR_KEPT: assert property (!busy && !$past(busy) |-> $stable(last_addr)) else $error("idle addr moved");
endmodule
bind frm_slave frm_chk i_chk (.clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .last_addr(last_addr));
`default_nettype wire

// [dv/frm_mst.sv]
// Behavioural bus master for the memory slave: start, stop and byte transfers.
// Assumes the bench resolves sda as an open-drain wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module frm_mst (
    // Time base and bus wires.
    input wire logic clock,
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // The bus idles with the clock high and data released.
    initial {scl, sda_pull} = 2'b10;
    // One quarter of the 160 ns bit; changes land on falling edges, clear of sampling.
    task automatic ph(input logic c, input logic p);
        scl = c;
        sda_pull = p;
        repeat (4) @(negedge clock);
    endtask
    // Data is only pulled low or released, never driven high.
    task automatic sbit(input logic b, output logic s);
        ph(1'b0, !b);
        ph(1'b1, !b);
        s = sda;
        ph(1'b1, !b);
        ph(1'b0, !b);
    endtask
    // Start (data falls) or stop (data rises) while the clock is high.
    task automatic cond(input logic st);
        ph(scl, !st);
        ph(1'b1, !st);
        ph(1'b1, st);
        if (st) begin
            ph(1'b0, st);
        end
    endtask
    // Eight bits MSB first, then the ninth: a writer releases it, a reader answers.
    task automatic sbyte(input logic [7:0] d, input logic a_out, output logic [7:0] got, output logic a_in);
        for (int i = 7; i >= 0; i--) begin
            sbit(d[i], got[i]);
        end
        sbit(a_out, a_in);
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Bench for the two-wire memory slave driven by the behavioural master.
// Assumes array content is unknown until written, so every read follows a write.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Type code for the slave; the value is arbitrary.
    localparam logic [3:0] TCODE = 4'h6;
    logic clock;
    logic nrst;
    logic wp;
    logic ack;
    // The master model drives these two; the bench only watches them.
    wire logic scl;
    wire logic sda_pull;
    logic [7:0] got, e;
    wire logic sda_oe, sda_out, busy;
    wire logic [10:0] last_addr;
    int err_total = 0, tests_run = 0, cycles = 0;
    // Open-drain wire: the pull-up wins unless a party pulls low.
    wire logic sda = (sda_oe ? sda_out : 1'b1) && !sda_pull;
    initial begin
        clock = 1'b0;
        forever #5 clock = !clock;
    end
    frm_slave #(.DEV_TYPE(TCODE)) i_dut (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .busy(busy), .last_addr(last_addr));
    frm_mst i_mst (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda(sda));
    // Compares one value and counts it.
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Access of n bytes from a: writes d upward, or reads them after a repeated start.
    task automatic acc(input logic [10:0] a, input int n, input logic [7:0] d, input logic rd);
        i_mst.cond(1'b1);
        i_mst.sbyte({TCODE, a[10:8], 1'b0}, 1'b1, got, ack);
        chk(ack, 1'b0);
        i_mst.sbyte(a[7:0], 1'b1, got, ack);
        chk(ack, 1'b0);
        if (rd) begin
            i_mst.cond(1'b1);
            i_mst.sbyte({TCODE, a[10:8], 1'b1}, 1'b1, got, ack);
            chk(ack, 1'b0);
        end
        for (int i = 0; i < n; i++) begin
            e = d + 8'(i);
            i_mst.sbyte(rd ? 8'hFF : e, rd ? (i == n - 1) : 1'b1, got, ack);
            chk(rd ? got : {7'h00, ack}, rd ? e : 8'h00);
        end
        i_mst.cond(1'b0);
    endtask
    // Page write over the top of the array, read back across the same wrap.
    task automatic t_wrap;
        acc(11'h7FE, 3, 8'h11, 1'b0);
        acc(11'h7FE, 3, 8'h11, 1'b1);
        chk(last_addr, 11'h000);
    endtask
    // Current read: upper bits from the word, low byte from the buffer, plus one.
    task automatic t_current;
        acc(11'h106, 1, 8'hB6, 1'b0);
        acc(11'h305, 2, 8'hA0, 1'b0);
        acc(11'h305, 1, 8'hA0, 1'b1);
        i_mst.cond(1'b1);
        i_mst.sbyte({TCODE, 3'h1, 1'b1}, 1'b1, got, ack);
        chk(ack, 1'b0);
        i_mst.sbyte(8'hFF, 1'b1, got, ack);
        chk(got, 8'hB6);
        i_mst.cond(1'b0);
        chk(last_addr, 11'h106);
    endtask
    // A protected write is acknowledged but changes nothing; reads still work with protect high.
    task automatic t_protect;
        wp = 1'b1;
        acc(11'h305, 1, 8'hEE, 1'b0);
        acc(11'h305, 2, 8'hA0, 1'b1);
        wp = 1'b0;
    endtask
    // Wrong type code gets no acknowledge; a stop in mid byte writes nothing.
    task automatic t_refuse;
        i_mst.cond(1'b1);
        i_mst.sbyte({~TCODE, 3'h3, 1'b0}, 1'b1, got, ack);
        chk(ack, 1'b1);
        i_mst.cond(1'b0);
        i_mst.cond(1'b1);
        i_mst.sbyte({TCODE, 3'h3, 1'b0}, 1'b1, got, ack);
        i_mst.sbyte(8'h05, 1'b1, got, ack);
        for (int i = 0; i < 4; i++) begin
            i_mst.sbit(1'b0, ack);
        end
        i_mst.cond(1'b0);
        i_mst.ph(1'b1, 1'b0);
        chk(busy, 1'b0);
        acc(11'h305, 1, 8'hA0, 1'b1);
    endtask
    initial begin
        nrst = 1'b0;
        wp = 1'b0;
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        t_wrap;
        t_current;
        t_protect;
        t_refuse;
        wrap_up;
    end
    // Cuts a hang short; the run needs about 6100 cycles.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            wrap_up;
        end
    end
endmodule
`default_nettype wire

// [inc/frm_regs.vh]
// Shared constants for the two-wire memory slave: widths, depths, counts and reset values.
// Assumes it is included by bare name from the design files under rtl/.
//
// How it works
// - Receiver pulls data low on ninth clock.
// - Transmitter releases data line on ninth clock.
// - Stop before acknowledge abandons operation, standby.
// - After not-acknowledge, release bus; master restarts/stops.
// - Eleven-bit address buffer feeds every access.
// - Full address: three word bits plus byte.
// - Device word: type, upper address, direction.
// - Wrong type code: no access, stay standby.
// - Three bits are address, never pin select.
// - Lower byte for write/random; current uses buffer.
// - Acknowledge lower address and each data byte.
// - No busy time; new word acknowledged immediately.
// - Write-protect high suppresses writes; reads always work.
// - Page write increments, wrapping last to zero.
// - Buffer keeps last accessed address after stop.
// - Current read returns address n plus one; the code takes the upper three bits from the device word instead.
// - Acknowledged reads continue at incrementing addresses.
// - Sample on clock rise, change on fall.
// - Stop ends any transfer, returns to standby.
`ifndef FRM_REGS_VH
`define FRM_REGS_VH

// Memory geometry.
`define FRM_ADDR_W 11
`define FRM_DATA_W 8
`define FRM_MEM_DEPTH 2048

// Write buffer geometry: one entry holds address and data.
`define FRM_FIFO_W 19
`define FRM_FIFO_DEPTH 32
`define FRM_FIFO_AW 5

// Device word field positions.
`define FRM_TYPE_HI 7
`define FRM_TYPE_LO 4
`define FRM_UPPER_HI 3
`define FRM_UPPER_LO 1
`define FRM_RW_BIT 0

// Bit count at which a byte is complete and the ninth clock begins.
`define FRM_BYTE_BITS 4'h8

// Reset values.
`define FRM_ADDR_RST 11'h000
`define FRM_SHIFT_RST 8'h00

`endif

// [rtl/frm_fifo.v]
// Flip-flop FIFO with valid/ready on both sides and honest full and empty.
// Assumes a single clock and an active-low asynchronous reset shared with the writer and reader.
`timescale 1ns/1ps
`default_nettype none
module frm_fifo #(
    parameter W = 19,
    parameter D = 32,
    parameter AW = 5
) (
    // Clock and reset.
    input wire clock,
    input wire nrst,
    // Filling side.
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Draining side.
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] store_q [0:D-1]; // Entry storage, indexed by pointer.
    reg [AW:0] wptr_reg; // Write pointer with wrap bit.
    reg [AW:0] rptr_reg; // Read pointer with wrap bit.
    wire full;
    wire empty;
    wire do_push;
    wire do_pop;

    // Full when the pointers match but have wrapped a different number of times.
    assign full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    assign empty = (wptr_reg == rptr_reg);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = store_q[rptr_reg[AW-1:0]];
    assign do_push = in_valid & ~full;
    assign do_pop = out_ready & ~empty;

    // Storage carries no reset; only pointers define the contents.
    always @(posedge clock) begin
        if (do_push) begin
            store_q[wptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointer updates.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wptr_reg <= {(AW+1){1'b0}};
            rptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (do_pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/frm_slave.v]
// Two-wire serial slave front end of a 2048-byte byte-addressable memory, with the array itself.
// Assumes scl_in, sda_in and wp come straight from pins and are slow against the 100 MHz clock;
// the data pin is open drain and the surrounding logic resolves it from sda_oe.
`timescale 1ns/1ps
`default_nettype none
`include "frm_regs.vh"
module frm_slave #(
    // Device type code; the value is arbitrary and stands in for the real one.
    parameter [3:0] DEV_TYPE = 4'hC
) (
    // Clock and reset.
    input wire clock,
    input wire nrst,
    // Serial bus pins.
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Write protect pin.
    input wire wp,
    // Status.
    output wire busy,
    output wire [`FRM_ADDR_W-1:0] last_addr
);
    // Protocol states.
    localparam [2:0] ST_IDLE = 3'h0; // Standby or released bus after a refusal.
    localparam [2:0] ST_DEV = 3'h1; // Receiving the device word.
    localparam [2:0] ST_ADDR = 3'h2; // Receiving the lower address byte.
    localparam [2:0] ST_WR = 3'h3; // Receiving write data.
    localparam [2:0] ST_ACK = 3'h4; // Driving an acknowledge on the ninth clock.
    localparam [2:0] ST_RD = 3'h5; // Shifting read data out.
    localparam [2:0] ST_RACK = 3'h6; // Listening to the master's acknowledge.
    localparam [2:0] ST_RLOAD = 3'h7; // Waiting for the fall that starts the next byte.

    // Next access address: the stored one if freshly loaded, otherwise one past it.
    // The 11-bit sum wraps from the last address to zero by itself.
    function [`FRM_ADDR_W-1:0] next_addr;
        input [`FRM_ADDR_W-1:0] a;
        input fresh;
        begin
            next_addr = fresh ? a : a + 1'b1;
        end
    endfunction

    // Pin synchronisers; the first stage of each is read only by its second stage.
    reg scl_m_reg;
    reg scl_s_reg;
    reg scl_d_reg; // Delayed copy of the synchronised clock for edge finding.
    reg sda_m_reg;
    reg sda_s_reg;
    reg sda_d_reg; // Delayed copy of the synchronised data for start and stop.
    reg wp_m_reg;
    reg wp_s_reg;

    // Protocol state.
    reg [2:0] st_reg; // Current protocol state.
    reg [2:0] nxt_reg; // State to enter after the acknowledge clock.
    reg [3:0] cnt_reg; // Clock rises seen in the current byte.
    reg [7:0] sh_reg; // Shift register for both directions.
    reg oe_reg; // High while the data pin is pulled low.
    reg [`FRM_ADDR_W-1:0] addr_reg; // Memory address buffer.
    reg fresh_reg; // Buffer holds a target not yet accessed.

    // Memory array as flip-flops.
    reg [7:0] mem_q [0:`FRM_MEM_DEPTH-1];

    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;
    wire [`FRM_ADDR_W-1:0] tgt;
    wire [7:0] rd_byte;
    wire load_now;
    wire byte_done;
    wire wr_push;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`FRM_FIFO_W-1:0] fifo_out_data;
    wire drain_ready;

    // Bring the pins into the clock domain before any logic looks at them.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            wp_m_reg <= 1'b0;
            wp_s_reg <= 1'b0;
        end else begin
            scl_m_reg <= scl_in;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= sda_in;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
            wp_m_reg <= wp;
            wp_s_reg <= wp_m_reg;
        end
    end

    // Edges of the serial clock and the two bus conditions, all from synchronised copies.
    assign scl_rise = scl_s_reg & ~scl_d_reg;
    assign scl_fall = ~scl_s_reg & scl_d_reg;
    assign bus_start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    assign bus_stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

    // Address of the next access, shared by reads and writes.
    assign tgt = next_addr(addr_reg, fresh_reg);
    assign rd_byte = mem_q[tgt];
    assign byte_done = scl_fall & (cnt_reg == `FRM_BYTE_BITS);

    // A read byte is fetched on the fall that ends an acknowledge toward a read.
    assign load_now = scl_fall & (((st_reg == ST_ACK) & (nxt_reg == ST_RD)) | (st_reg == ST_RLOAD));

    // Received data goes to the write buffer unless write protect is high.
    assign wr_push = byte_done & (st_reg == ST_WR) & ~wp_s_reg;

    // The array read port and the drain share a cycle only when no read fetch is due,
    // so a fetch stalls the drain for one clock.
    assign drain_ready = ~load_now;

    // Open-drain pin: only ever drives low.
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;
    assign busy = (st_reg != ST_IDLE);
    assign last_addr = addr_reg;

    // Write buffer between the serial side and the array.
    frm_fifo #(
        .W(`FRM_FIFO_W),
        .D(`FRM_FIFO_DEPTH),
        .AW(`FRM_FIFO_AW)
    ) u_wbuf (
        .clock(clock),
        .nrst(nrst),
        .in_valid(wr_push),
        .in_ready(fifo_in_ready),
        .in_data({tgt, sh_reg}),
        .out_valid(fifo_out_valid),
        .out_ready(drain_ready),
        .out_data(fifo_out_data)
    );

    // Drain the buffer into the array. A byte lands one clock after it is pushed,
    // long before the acknowledge clock ends, so no stop or start has to wait.
    always @(posedge clock) begin
        if (fifo_out_valid && drain_ready) begin
            mem_q[fifo_out_data[`FRM_FIFO_W-1:8]] <= fifo_out_data[7:0];
        end
    end

    // Protocol engine. Bus conditions take priority over bit-level work.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_IDLE;
            nxt_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= `FRM_SHIFT_RST;
            oe_reg <= 1'b0;
            addr_reg <= `FRM_ADDR_RST;
            fresh_reg <= 1'b0;
        end else if (bus_start) begin
            // A start or repeated start always opens a fresh device word.
            st_reg <= ST_DEV;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
        end else if (bus_stop) begin
            // Stop ends everything; the address buffer keeps its value.
            st_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
        end else if (load_now) begin
            // Fetch the next read byte and put its first bit on the line.
            sh_reg <= rd_byte;
            oe_reg <= ~rd_byte[7];
            addr_reg <= tgt;
            fresh_reg <= 1'b0;
            st_reg <= ST_RD;
            cnt_reg <= 4'h0;
        end else begin
            case (st_reg)
                ST_DEV, ST_ADDR, ST_WR: begin
                    if (scl_rise && cnt_reg != `FRM_BYTE_BITS) begin
                        // Sample on the rising edge, MSB first.
                        sh_reg <= {sh_reg[6:0], sda_s_reg};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        if (st_reg == ST_DEV) begin
                            // Type code must match; the next three bits are address only.
                            if (sh_reg[`FRM_TYPE_HI:`FRM_TYPE_LO] == DEV_TYPE) begin
                                addr_reg[10:8] <= sh_reg[`FRM_UPPER_HI:`FRM_UPPER_LO];
                                nxt_reg <= sh_reg[`FRM_RW_BIT] ? ST_RD : ST_ADDR;
                                oe_reg <= 1'b1;
                                st_reg <= ST_ACK;
                            end else begin
                                st_reg <= ST_IDLE;
                            end
                        end else if (st_reg == ST_ADDR) begin
                            // Lower byte completes the target; it is accessed next.
                            addr_reg[7:0] <= sh_reg;
                            fresh_reg <= 1'b1;
                            nxt_reg <= ST_WR;
                            oe_reg <= 1'b1;
                            st_reg <= ST_ACK;
                        end else if (wp_s_reg || fifo_in_ready) begin
                            // Data byte: the address advances even when protect drops it.
                            addr_reg <= tgt;
                            fresh_reg <= 1'b0;
                            nxt_reg <= ST_WR;
                            oe_reg <= 1'b1;
                            st_reg <= ST_ACK;
                        end else begin
                            // A full buffer refuses the byte with a not-acknowledge.
                            st_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    // The read case is handled by the fetch branch above.
                    if (scl_fall) begin
                        oe_reg <= 1'b0;
                        cnt_reg <= 4'h0;
                        st_reg <= nxt_reg;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        // Let go for the master's acknowledge.
                        oe_reg <= 1'b0;
                        st_reg <= ST_RACK;
                    end else if (scl_fall && cnt_reg != 4'h0) begin
                        // Change data only after a falling edge.
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        oe_reg <= ~sh_reg[6];
                    end
                end
                ST_RACK: begin
                    // Low continues the read, high releases the bus until stop or start.
                    if (scl_rise) begin
                        st_reg <= sda_s_reg ? ST_IDLE : ST_RLOAD;
                    end
                end
                ST_RLOAD: begin
                    // Waiting for the fall; the fetch branch takes it.
                    st_reg <= ST_RLOAD;
                end
                default: begin
                    // Idle: stay released until a start.
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire
